// [rtl/gli_byte_buffer.sv]
// Purpose: Two-entry buffer between processor writes and the source handshake.
// Assumes: Same clock as its producer and consumer.
// Notes: Head data come straight from a register.
module gli_byte_buffer (
   input wire logic clk,
   input wire logic srst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [gli_pkg::BUF_WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [gli_pkg::BUF_WIDTH-1:0] outData
);
   typedef struct packed {
      logic [gli_pkg::BUF_WIDTH-1:0] head;
      logic [gli_pkg::BUF_WIDTH-1:0] tail;
      logic [1:0] count;
   } glb_state_s;
   glb_state_s buf_ff;
   glb_state_s nxt_buf;
   logic push;
   logic pop;

   assign inReady = (buf_ff.count != 2'h2);
   assign outValid = (buf_ff.count != 2'h0);
   assign outData = buf_ff.head;
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      nxt_buf = buf_ff;
      if (pop) begin
         nxt_buf.head = buf_ff.tail;
      end
      if (push) begin
         if (buf_ff.count == 2'h0 || (buf_ff.count == 2'h1 && pop)) begin
            nxt_buf.head = inData;
         end else begin
            nxt_buf.tail = inData;
         end
      end
      nxt_buf.count = buf_ff.count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         buf_ff <= '0;
      end else begin
         buf_ff <= nxt_buf;
      end
   end
endmodule : gli_byte_buffer

// [rtl/gli_listener_interface.sv]
// Purpose: Instrument side bus interface with processor registers and both handshakes.
// Assumes: Bus pins are asynchronous and pass two flip-flops; processor signals share clk.
// Notes: Open-drain DAV and data pins are split into level, value and active-low enable; EOI into value and enable.
module gli_listener_interface (
   input wire logic clk,
   input wire logic srst,
   input wire logic ifChipSel,
   input wire logic phase2Active,
   input wire logic lowAddrBit0,
   input wire logic lowAddrBit1,
   input wire logic readWriteLine,
   input wire logic [7:0] cpuWrData,
   output logic [7:0] cpuRdData,
   output logic txReady,
   output logic processorIrqN,
   input wire logic [4:0] ownAddress,
   input wire logic attentionActiveLow,
   input wire logic validActiveLowIn,
   output logic validActiveLowOut,
   output logic validOeN,
   input wire logic [7:0] dioIn,
   output logic [7:0] dioOut,
   output logic dioOeN,
   output logic eoiOut,
   output logic eoiOeN,
   output logic acceptedActiveHigh,
   output logic readyForByteActiveHigh,
   input wire logic peerAccepted,
   input wire logic peerReady
);
   typedef enum logic [1:0] {A_IDLE, A_CONF, A_STRB, A_ACC} gli_acc_e;
   typedef enum logic [1:0] {T_IDLE, T_GAP, T_RFD, T_DAV} gli_tx_e;
   typedef struct packed {
      gli_acc_e accSt;
      gli_tx_e txSt;
      logic [1:0] txCnt;
      logic listen;
      logic talk;
      logic spoll;
      logic remote;
      logic srqFlag;
      logic dataAvail;
      logic cmdPend;
      logic irqFlag;
      logic txDone;
      logic rfdHold;
      logic accPrev;
      logic davOut;
      logic eoiOn;
      logic driveOn;
      logic [7:0] dinReg;
      logic [7:0] pollReg;
      logic [7:0] ctrlReg;
      logic [7:0] rdData;
      logic [7:0] dioOutReg;
      logic [3:0] cmdCode;
      logic [7:0] dioS1;
      logic [7:0] dioS2;
      logic attnS1;
      logic attnS2;
      logic davS1;
      logic davS2;
      logic pAccS1;
      logic pAccS2;
      logic pRdyS1;
      logic pRdyS2;
   } gli_state_s;

   gli_state_s st_ff;
   gli_state_s nxt_st;
   logic access;
   logic accessPulse;
   logic [7:0] sel;
   logic [7:0] ctrlRise;
   logic bufValid;
   logic bufPop;
   logic bufPush;
   logic [7:0] bufData;
   logic attnOn;
   logic accEnable;
   logic txEnable;
   logic [6:0] busByte;

   ////////////////////////////////////////////////////////////////////////////////
   // Register select decode. Each access acts once, on its first phase-2 clock.

   assign access = ifChipSel && phase2Active;
   assign accessPulse = access && !st_ff.accPrev;

   generate
      for (genvar i = 0; i < 8; i++) begin : g_sel
         assign sel[i] = accessPulse && ({readWriteLine, lowAddrBit1, lowAddrBit0} == 3'(i));
      end
   endgenerate

   assign ctrlRise = (sel[gli_pkg::SEL_CTRL]) ? (cpuWrData & ~st_ff.ctrlReg) : 8'h00;
   assign attnOn = !st_ff.attnS2;
   assign accEnable = attnOn || st_ff.listen;
   assign txEnable = st_ff.talk && !attnOn;
   assign busByte = st_ff.dioS2[6:0];
   assign bufPush = sel[gli_pkg::SEL_DOUT] && !st_ff.spoll;

   ////////////////////////////////////////////////////////////////////////////////
   // Outgoing byte buffer. A full buffer shows on txReady and the write is dropped.

   gli_byte_buffer u_txbuf (
      .clk(clk),
      .srst(srst),
      .inValid(bufPush),
      .inReady(txReady),
      .inData(cpuWrData),
      .outValid(bufValid),
      .outReady(bufPop),
      .outData(bufData)
   );

   assign bufPop = (st_ff.txSt == T_DAV) && st_ff.pAccS2 && txEnable;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      nxt_st = st_ff;
      nxt_st.dioS1 = dioIn;
      nxt_st.dioS2 = st_ff.dioS1;
      nxt_st.attnS1 = attentionActiveLow;
      nxt_st.attnS2 = st_ff.attnS1;
      nxt_st.davS1 = validActiveLowIn;
      nxt_st.davS2 = st_ff.davS1;
      nxt_st.pAccS1 = peerAccepted;
      nxt_st.pAccS2 = st_ff.pAccS1;
      nxt_st.pRdyS1 = peerReady;
      nxt_st.pRdyS2 = st_ff.pRdyS1;
      nxt_st.accPrev = access;

      // Processor reads capture data; clears come before hardware sets so a set wins.
      if (sel[gli_pkg::SEL_STATE]) begin
         nxt_st.rdData = {3'h0, st_ff.srqFlag, st_ff.remote, st_ff.spoll, st_ff.talk, st_ff.listen};
      end
      if (sel[gli_pkg::SEL_CMD]) begin
         nxt_st.rdData = {4'h0, st_ff.cmdCode};
         nxt_st.cmdPend = 1'b0;
      end
      if (sel[gli_pkg::SEL_CAUSE]) begin
         nxt_st.rdData = {5'h00, st_ff.txDone, st_ff.cmdPend, st_ff.dataAvail};
         nxt_st.irqFlag = 1'b0;
      end
      if (sel[gli_pkg::SEL_DIN]) begin
         nxt_st.rdData = st_ff.dinReg;
         nxt_st.dataAvail = 1'b0;
         nxt_st.rfdHold = 1'b0;
      end
      if (sel[gli_pkg::SEL_CTRL]) begin
         nxt_st.ctrlReg = cpuWrData;
      end
      if (sel[gli_pkg::SEL_POLL]) begin
         nxt_st.pollReg = cpuWrData;
         nxt_st.srqFlag = cpuWrData[gli_pkg::POLL_SRQ];
      end
      if (bufPush) begin
         nxt_st.txDone = 1'b0;
      end
      if (ctrlRise[gli_pkg::CTRL_LOCAL]) begin
         nxt_st.remote = 1'b0;
      end
      if (ctrlRise[gli_pkg::CTRL_UNADDR]) begin
         nxt_st.spoll = 1'b0;
         nxt_st.talk = 1'b0;
         nxt_st.listen = 1'b0;
      end

      // Acceptor handshake. DAV is confirmed on two edges to reject a glitch.
      case (st_ff.accSt)
         A_IDLE: begin
            if (accEnable && !st_ff.davS2 && !st_ff.rfdHold) begin
               nxt_st.accSt = A_CONF;
            end
         end
         A_CONF: begin
            nxt_st.accSt = (!st_ff.davS2 && accEnable) ? A_STRB : A_IDLE;
         end
         A_STRB: begin
            nxt_st.accSt = A_ACC;
            if (attnOn) begin
               if (busByte == gli_pkg::BUS_UNL) begin
                  nxt_st.listen = 1'b0;
               end else if (busByte[6:5] == gli_pkg::BUS_LAG && busByte[4:0] == ownAddress) begin
                  nxt_st.listen = 1'b1;
                  nxt_st.remote = 1'b1;
               end else if (busByte[6:5] == gli_pkg::BUS_TAG) begin
                  nxt_st.talk = (busByte[4:0] == ownAddress);
               end else if (busByte == gli_pkg::BUS_SPE) begin
                  nxt_st.spoll = 1'b1;
               end else if (busByte == gli_pkg::BUS_SPD) begin
                  nxt_st.spoll = 1'b0;
               end else if (busByte == gli_pkg::BUS_LLO || busByte == gli_pkg::BUS_DCL ||
                            (st_ff.listen && (busByte == gli_pkg::BUS_GTL ||
                             busByte == gli_pkg::BUS_SDC || busByte == gli_pkg::BUS_GET))) begin
                  nxt_st.cmdPend = 1'b1;
                  nxt_st.irqFlag = 1'b1;
                  case (busByte)
                     gli_pkg::BUS_LLO: nxt_st.cmdCode = gli_pkg::CODE_LLO;
                     gli_pkg::BUS_DCL: nxt_st.cmdCode = gli_pkg::CODE_DCL;
                     gli_pkg::BUS_GTL: nxt_st.cmdCode = gli_pkg::CODE_GTL;
                     gli_pkg::BUS_SDC: nxt_st.cmdCode = gli_pkg::CODE_SDC;
                     default: nxt_st.cmdCode = gli_pkg::CODE_GET;
                  endcase
               end
            end else if (st_ff.listen) begin
               nxt_st.dinReg = st_ff.dioS2;
               nxt_st.dataAvail = 1'b1;
               nxt_st.irqFlag = 1'b1;
               nxt_st.rfdHold = 1'b1;
            end
         end
         A_ACC: begin
            if (st_ff.davS2) begin
               nxt_st.accSt = A_IDLE;
            end
         end
         default: nxt_st.accSt = A_IDLE;
      endcase

      // Source handshake. Leaving talk or seeing ATN drops DAV and the drivers at once.
      nxt_st.eoiOn = 1'b0;
      if (!txEnable) begin
         nxt_st.txSt = T_IDLE;
         nxt_st.davOut = 1'b0;
      end else begin
         case (st_ff.txSt)
            T_IDLE: begin
               if (bufValid) begin
                  nxt_st.txSt = T_GAP;
                  nxt_st.txCnt = 2'h1;
               end
            end
            T_GAP: begin
               nxt_st.txCnt = st_ff.txCnt + 2'h1;
               if (st_ff.txCnt >= gli_pkg::DAV_DELAY - 2'h1) begin
                  nxt_st.txSt = T_RFD;
               end
            end
            T_RFD: begin
               if (st_ff.pRdyS2) begin
                  nxt_st.txSt = T_DAV;
                  nxt_st.davOut = 1'b1;
               end
            end
            T_DAV: begin
               if (st_ff.pAccS2) begin
                  nxt_st.txSt = T_IDLE;
                  nxt_st.davOut = 1'b0;
                  nxt_st.txDone = 1'b1;
               end
            end
            default: nxt_st.txSt = T_IDLE;
         endcase
      end
      if (nxt_st.davOut && !st_ff.ctrlReg[gli_pkg::CTRL_EOM] && bufData == gli_pkg::BYTE_LF) begin
         nxt_st.eoiOn = 1'b1;
      end

      // Data lines carry the poll byte in poll mode, otherwise the buffer head.
      nxt_st.driveOn = txEnable && (st_ff.spoll || nxt_st.txSt != T_IDLE);
      nxt_st.dioOutReg = st_ff.spoll ? st_ff.pollReg : bufData;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= '0;
         st_ff.accSt <= A_IDLE;
         st_ff.txSt <= T_IDLE;
         st_ff.dinReg <= gli_pkg::RST_BYTE;
         st_ff.pollReg <= gli_pkg::RST_BYTE;
         st_ff.ctrlReg <= gli_pkg::RST_CTRL;
         st_ff.cmdCode <= gli_pkg::RST_CODE;
         st_ff.txDone <= 1'b1;
         st_ff.attnS1 <= 1'b1;
         st_ff.attnS2 <= 1'b1;
         st_ff.davS1 <= 1'b1;
         st_ff.davS2 <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign cpuRdData = st_ff.rdData;
   assign processorIrqN = !st_ff.irqFlag;
   assign acceptedActiveHigh = (st_ff.accSt == A_ACC);
   assign readyForByteActiveHigh = !st_ff.rfdHold && (st_ff.accSt == A_IDLE);
   assign validActiveLowOut = 1'b0;
   assign validOeN = !st_ff.davOut;
   assign dioOut = st_ff.dioOutReg;
   assign dioOeN = !st_ff.driveOn;
   assign eoiOut = 1'b0;
   assign eoiOeN = !st_ff.eoiOn;
endmodule : gli_listener_interface

// [rtl/gli_pkg.sv]
// Purpose: Constants for the bus listener interface block.
// Assumes: One clock domain; register selects follow the read/write line and two address bits.
// Notes: Bus bytes are compared on their low seven bits.
package gli_pkg;
   localparam logic [2:0] SEL_STATE = 3'h0;
   localparam logic [2:0] SEL_CMD = 3'h1;
   localparam logic [2:0] SEL_CAUSE = 3'h2;
   localparam logic [2:0] SEL_DIN = 3'h3;
   localparam logic [2:0] SEL_CTRL = 3'h5;
   localparam logic [2:0] SEL_POLL = 3'h6;
   localparam logic [2:0] SEL_DOUT = 3'h7;
   localparam int ST_LISTEN = 0;
   localparam int ST_TALK = 1;
   localparam int ST_SPOLL = 2;
   localparam int ST_REMOTE = 3;
   localparam int ST_SRQ = 4;
   localparam int CAUSE_DATA = 0;
   localparam int CAUSE_CMD = 1;
   localparam int CAUSE_TXDONE = 2;
   localparam int CTRL_LOCAL = 0;
   localparam int CTRL_UNADDR = 1;
   localparam int CTRL_EOM = 2;
   localparam int POLL_SRQ = 6;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'hFF;
   localparam logic [3:0] RST_CODE = 4'h0;
   localparam logic [6:0] BUS_UNL = 7'h3F;
   localparam logic [1:0] BUS_LAG = 2'h1;
   localparam logic [1:0] BUS_TAG = 2'h2;
   localparam logic [6:0] BUS_SPE = 7'h18;
   localparam logic [6:0] BUS_SPD = 7'h19;
   localparam logic [6:0] BUS_LLO = 7'h11;
   localparam logic [6:0] BUS_DCL = 7'h14;
   localparam logic [6:0] BUS_GTL = 7'h01;
   localparam logic [6:0] BUS_SDC = 7'h04;
   localparam logic [6:0] BUS_GET = 7'h08;
   localparam logic [3:0] CODE_LLO = 4'h1;
   localparam logic [3:0] CODE_DCL = 4'h9;
   localparam logic [3:0] CODE_GTL = 4'h2;
   localparam logic [3:0] CODE_SDC = 4'hA;
   localparam logic [3:0] CODE_GET = 4'h6;
   localparam logic [7:0] BYTE_LF = 8'h0A;
   localparam logic [1:0] DAV_DELAY = 2'h2;
   localparam int BUF_WIDTH = 8;
endpackage : gli_pkg

// [testbench/gli_bus_peer.sv]
// Purpose: Far side of the bus: a talker task and a listener process.
// Assumes: Outputs change on the falling clock edge.
// Notes: Released data lines show the inverse of the last byte, so stale data never matches.
module gli_bus_peer (
   input wire logic clk,
   input wire logic stall,
   input wire logic acceptedActiveHigh,
   input wire logic readyForByteActiveHigh,
   input wire logic validOeN,
   input wire logic [7:0] dioOut,
   input wire logic dioOeN,
   input wire logic eoiOeN,
   output logic attentionActiveLow,
   output logic validActiveLowIn,
   output logic [7:0] dioIn,
   output logic peerAccepted,
   output logic peerReady
);
   timeunit 1ns;
   timeprecision 1ps;
   logic talkDav;
   logic [7:0] talkData;
   int rxQ[$];
   assign validActiveLowIn = talkDav & validOeN;
   assign dioIn = dioOeN ? talkData : dioOut;
   initial begin
      attentionActiveLow = 1'b1;
      talkDav = 1'b1;
      talkData = 8'h00;
      peerAccepted = 1'b0;
      peerReady = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic send(input logic [7:0] b, input logic atnLow);
      int n;
      n = 0;
      @(negedge clk);
      attentionActiveLow = atnLow;
      talkData = b;
      while (!readyForByteActiveHigh && n < 50) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      talkDav = 1'b0;
      n = 0;
      while (!acceptedActiveHigh && n < 20) begin
         @(negedge clk);
         n++;
      end
      talkData = ~b;
      talkDav = 1'b1;
      repeat (6) @(negedge clk);
      attentionActiveLow = 1'b1;
   endtask : send
   // The stall input pulls peerReady low at the next falling edge with DAV released, used or not, holding the device's talker off for as long as it likes.
   always @(negedge clk) begin
      if (!validOeN && peerReady) begin
         rxQ.push_back(int'({!eoiOeN, dioIn}));
         peerReady <= 1'b0;
         peerAccepted <= 1'b1;
      end else if (validOeN) begin
         peerAccepted <= 1'b0;
         peerReady <= !stall;
      end
   end
endmodule : gli_bus_peer

// [testbench/gli_listener_interface_monitor.sv]
// Purpose: Concurrent checks on the listener interface ports.
// Assumes: One clock; srst is synchronous and active high.
// Notes: Bus inputs pass two flip-flops, so delay ranges allow for that.
module gli_listener_interface_monitor (
   input wire logic clk,
   input wire logic srst,
   input wire logic ifChipSel,
   input wire logic phase2Active,
   input wire logic lowAddrBit0,
   input wire logic lowAddrBit1,
   input wire logic readWriteLine,
   input wire logic processorIrqN,
   input wire logic validActiveLowIn,
   input wire logic validOeN,
   input wire logic [7:0] dioOut,
   input wire logic dioOeN,
   input wire logic eoiOeN,
   input wire logic acceptedActiveHigh,
   input wire logic readyForByteActiveHigh,
   input wire logic peerAccepted,
   input wire logic peerReady
);
   timeunit 1ns;
   timeprecision 1ps;
   logic acc;
   assign acc = ifChipSel & phase2Active;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////
   chk_reset_idle: assert property (
      disable iff (1'b0) srst |=> processorIrqN && !acceptedActiveHigh && readyForByteActiveHigh
      && validOeN && dioOeN && eoiOeN) else $error("Outputs not idle after reset.");
   chk_cause_clears: assert property (
      acc && !$past(acc) && !readWriteLine && lowAddrBit1 && !lowAddrBit0
      |=> processorIrqN || $fell(processorIrqN)) else $error("Cause read left interrupt.");
   chk_accept_nrfd: assert property (
      $rose(acceptedActiveHigh) |-> !readyForByteActiveHigh && !$past(validActiveLowIn, 4))
      else $error("Accepted with ready high or unconfirmed valid.");
   chk_irq_accept: assert property (
      $fell(processorIrqN) |-> ##[0:1] acceptedActiveHigh) else $error("Interrupt without capture.");
   chk_ndac_hold: assert property (
      acceptedActiveHigh && !validActiveLowIn |=> acceptedActiveHigh) else $error("Accepted dropped early.");
   chk_ndac_return: assert property (
      acceptedActiveHigh && $rose(validActiveLowIn) |-> ##[1:4] !acceptedActiveHigh)
      else $error("Accepted not returned.");
   chk_nrfd_release: assert property (
      acc && !$past(acc) && !readWriteLine && lowAddrBit1 && lowAddrBit0
      |-> ##[1:3] readyForByteActiveHigh) else $error("Ready not released.");
   chk_dav_data: assert property (
      !validOeN |-> !dioOeN) else $error("Valid without data drive.");
   chk_dav_release: assert property (
      !validOeN && peerAccepted |-> ##[1:4] validOeN) else $error("Valid held after accept.");
   chk_dav_ready: assert property (
      $fell(validOeN) |-> $past(peerReady, 3)) else $error("Valid before peer ready.");
   chk_eoi_lf: assert property (
      !eoiOeN |-> !dioOeN && dioOut == gli_pkg::BYTE_LF) else $error("End mark on wrong byte.");
endmodule : gli_listener_interface_monitor
////////////////////////////////////////////////////////////////////////
bind gli_listener_interface gli_listener_interface_monitor u_mon (.clk(clk), .srst(srst),
   .ifChipSel(ifChipSel), .phase2Active(phase2Active), .lowAddrBit0(lowAddrBit0),
   .lowAddrBit1(lowAddrBit1), .readWriteLine(readWriteLine), .processorIrqN(processorIrqN),
   .validActiveLowIn(validActiveLowIn), .validOeN(validOeN), .dioOut(dioOut), .dioOeN(dioOeN),
   .eoiOeN(eoiOeN), .acceptedActiveHigh(acceptedActiveHigh),
   .readyForByteActiveHigh(readyForByteActiveHigh), .peerAccepted(peerAccepted), .peerReady(peerReady));

// [testbench/gli_listener_interface_tb.sv]
// Purpose: Self-checking bench for the listener interface block.
// Assumes: Inputs change on the falling edge; the peer plays talker and listener.
// Notes: Flag expectations come from a small integer model kept here.
module gli_listener_interface_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, srst, ifChipSel, phase2Active, lowAddrBit0, lowAddrBit1, readWriteLine, stall;
   logic [7:0] cpuWrData, cpuRdData, dioIn, dioOut, rdv, b;
   logic [4:0] ownAddress;
   logic txReady, processorIrqN, attentionActiveLow, validActiveLowIn, validActiveLowOut, validOeN;
   logic dioOeN, eoiOut, eoiOeN, acceptedActiveHigh, readyForByteActiveHigh, peerAccepted, peerReady;
   int mismatches = 0;
   int checksDone = 0;
   int mListen = 0, mTalk = 0, mSpoll = 0, mRemote = 0, mSrq = 0, i, n;
   int txQ[$];
   logic [6:0] busCmd [5] = '{gli_pkg::BUS_LLO, gli_pkg::BUS_DCL, gli_pkg::BUS_GTL, gli_pkg::BUS_SDC,
      gli_pkg::BUS_GET};
   logic [3:0] codes [5] = '{gli_pkg::CODE_LLO, gli_pkg::CODE_DCL, gli_pkg::CODE_GTL, gli_pkg::CODE_SDC,
      gli_pkg::CODE_GET};
   gli_listener_interface u_dut (.clk(clk), .srst(srst), .ifChipSel(ifChipSel), .phase2Active(phase2Active),
      .lowAddrBit0(lowAddrBit0), .lowAddrBit1(lowAddrBit1), .readWriteLine(readWriteLine),
      .cpuWrData(cpuWrData), .cpuRdData(cpuRdData), .txReady(txReady), .processorIrqN(processorIrqN),
      .ownAddress(ownAddress), .attentionActiveLow(attentionActiveLow), .validActiveLowIn(validActiveLowIn),
      .validActiveLowOut(validActiveLowOut), .validOeN(validOeN), .dioIn(dioIn), .dioOut(dioOut),
      .dioOeN(dioOeN), .eoiOut(eoiOut), .eoiOeN(eoiOeN), .acceptedActiveHigh(acceptedActiveHigh),
      .readyForByteActiveHigh(readyForByteActiveHigh), .peerAccepted(peerAccepted), .peerReady(peerReady));
   gli_bus_peer u_peer (.clk(clk), .stall(stall), .acceptedActiveHigh(acceptedActiveHigh),
      .readyForByteActiveHigh(readyForByteActiveHigh), .validOeN(validOeN), .dioOut(dioOut),
      .dioOeN(dioOeN), .eoiOeN(eoiOeN), .attentionActiveLow(attentionActiveLow),
      .validActiveLowIn(validActiveLowIn), .dioIn(dioIn), .peerAccepted(peerAccepted), .peerReady(peerReady));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checksDone++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Access low for two cycles between accesses, as the register port needs a fresh rise.
   task automatic acc(input logic rw, input logic [1:0] a, input logic [7:0] wd, input logic p2);
      @(negedge clk);
      readWriteLine = rw;
      {lowAddrBit1, lowAddrBit0} = a;
      cpuWrData = wd;
      ifChipSel = 1'b1;
      phase2Active = p2;
      @(negedge clk);
      ifChipSel = 1'b0;
      phase2Active = 1'b0;
      @(negedge clk);
      rdv = cpuRdData;
   endtask : acc
   task automatic chkState();
      acc(1'b0, 2'h0, 8'h00, 1'b1);
      chk(rdv, {mSrq[0], mRemote[0], mSpoll[0], mTalk[0], mListen[0]});
   endtask : chkState
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      mismatches++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h723F83FB));
      {srst, ifChipSel, phase2Active, lowAddrBit0, lowAddrBit1, readWriteLine, stall} = 7'h40;
      cpuWrData = 8'h00;
      ownAddress = 5'($urandom % 31);
      repeat (4) @(negedge clk);
      srst = 1'b0;
      chk({processorIrqN, acceptedActiveHigh, readyForByteActiveHigh, txReady, validActiveLowOut, eoiOut,
         validOeN, dioOeN, eoiOeN}, 9'h167);
      chkState();
      u_peer.send({1'b0, gli_pkg::BUS_LAG, ownAddress}, 1'b0);
      mListen = 1;
      mRemote = 1;
      chkState();
      acc(1'b1, 2'h1, 8'hFE, 1'b1);
      acc(1'b1, 2'h1, 8'hFF, 1'b1);
      mRemote = 0;
      chkState();
      acc(1'b1, 2'h0, 8'hFD, 1'b1);
      chkState();
      for (i = 0; i < 3; i++) begin
         b = 8'($urandom);
         u_peer.send(b, 1'b1);
         acc(1'b0, 2'h2, 8'h00, 1'b0);
         chk(processorIrqN, 1'b0);
         acc(1'b0, 2'h2, 8'h00, 1'b1);
         chk({processorIrqN, rdv[1:0]}, 3'h5);
         acc(1'b0, 2'h3, 8'h00, 1'b1);
         chk(rdv, b);
      end
      for (i = 0; i < 5; i++) begin
         u_peer.send({1'b0, busCmd[i]}, 1'b0);
         acc(1'b0, 2'h2, 8'h00, 1'b1);
         chk({processorIrqN, rdv[1:0]}, 3'h6);
         acc(1'b0, 2'h1, 8'h00, 1'b1);
         chk(rdv[3:0], codes[i]);
      end
      acc(1'b1, 2'h1, 8'hFE, 1'b1);
      acc(1'b1, 2'h1, 8'hFF, 1'b1);
      u_peer.send({1'b0, gli_pkg::BUS_SPE}, 1'b0);
      mSpoll = 1;
      chkState();
      u_peer.send({1'b0, gli_pkg::BUS_SPD}, 1'b0);
      mSpoll = 0;
      chkState();
      u_peer.send({1'b0, gli_pkg::BUS_SPE}, 1'b0);
      acc(1'b1, 2'h1, 8'hFC, 1'b1);
      acc(1'b1, 2'h1, 8'hFF, 1'b1);
      mListen = 0;
      chkState();
      acc(1'b0, 2'h2, 8'h00, 1'b1);
      u_peer.send(8'($urandom), 1'b1);
      chk(processorIrqN, 1'b1);
      u_peer.send({1'b0, gli_pkg::BUS_TAG, ownAddress}, 1'b0);
      mTalk = 1;
      chkState();
      u_peer.send({1'b0, gli_pkg::BUS_TAG, 5'(ownAddress + 5'h01)}, 1'b0);
      mTalk = 0;
      chkState();
      u_peer.send({1'b0, gli_pkg::BUS_TAG, ownAddress}, 1'b0);
      mTalk = 1;
      acc(1'b1, 2'h2, 8'h50, 1'b1);
      mSrq = 1;
      chkState();
      // Poll mode while talking must put the poll byte on the lines and refuse data-out writes.
      u_peer.send({1'b0, gli_pkg::BUS_SPE}, 1'b0);
      repeat (4) @(negedge clk);
      chk({dioOeN, dioOut}, 9'h050);
      acc(1'b1, 2'h3, 8'hA5, 1'b1);
      u_peer.send({1'b0, gli_pkg::BUS_SPD}, 1'b0);
      stall = 1'b1;
      acc(1'b1, 2'h1, 8'hFB, 1'b1);
      for (n = 0; n < 8 && txReady; n++) begin
         b = 8'($urandom) | 8'h80;
         acc(1'b1, 2'h3, b, 1'b1);
         txQ.push_back(int'(b));
      end
      chk(txReady, 1'b0);
      acc(1'b1, 2'h3, 8'h55, 1'b1);
      stall = 1'b0;
      for (n = 0; n < 100 && !txReady; n++) @(negedge clk);
      acc(1'b1, 2'h3, gli_pkg::BYTE_LF, 1'b1);
      txQ.push_back(32'h10A);
      for (n = 0; n < 200 && u_peer.rxQ.size() < txQ.size(); n++) @(negedge clk);
      chk(9'(u_peer.rxQ.size()), 9'(txQ.size()));
      foreach (txQ[k]) chk(9'(u_peer.rxQ[k]), 9'(txQ[k]));
      chk(txReady, 1'b1);
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      mTalk = 0;
      mSrq = 0;
      chkState();
      give_verdict();
   end
endmodule : gli_listener_interface_tb
